/* File: framer_pkg.sv */
// Shared constants and types for the waveform transfer framer
// -----------------------------------------------------------
// Contract
// - Reset selects the full 1000-point trace and ASCII decimal encoding.
// - A newer trace selection from either command replaces the older one.
// - A half trace clears point coupling; coupling forces the full trace.
// - A curve command without destination uses the latest selection.
// - Half traces carry exactly 500 points, the full trace exactly 1000.
// - Binary block: percent, two-byte count of data plus one, data, checksum.
// - Checksum makes all bytes after the percent sum to zero modulo 256.
// - End block: at-sign, data bytes, end flag with the final data byte.
// - An end block is the last item of a message; nothing follows it.
// - ASCII points are decimal digit strings separated by commas.
// - Binary points are single unsigned bytes of 8 significant bits.
// - No per-byte check is added to binary data; only the block sum.
// - Preamble point count is 500 or 1000, following the trace selection.
// - Point offset is 250 half, 500 full in frequency, 0 in time domain.
// - Horizontal step divisor is 100 for the full trace, 50 for halves.
// - Vertical offset 225 in log, 25 in linear; scale divisor is 25.
// - A curve query earlier in the message overrides a received curve.
// - The curve command is rejected inside a stored macro.
// - Combined query returns the waveform preamble then the curve.
// - Copy query returns identity, waveform preamble, display preamble, curve.
// - Display preamble: 10, 8, centre 8, offset -9, multipliers 1, 0.04.
// - The settings report holds only trace selection and encoding.
// - Trace B refreshes every sweep; trace A only while hold is off.
// - Stored points alternate B and A left to right; full trace merges them.
// -----------------------------------------------------------
package framer_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_COMMAND = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_PREAMBLE = 8'h0C;
	localparam logic [7:0] ADDR_SCALE = 8'h10;
	localparam logic [7:0] ADDR_SETTINGS = 8'h14;
	localparam int CFG_ENC_BIT = 2;
	localparam int CFG_MPC_BIT = 3;
	localparam int CFG_HOLD_BIT = 4;
	localparam int CFG_FREQ_BIT = 5;
	localparam int CFG_LOG_BIT = 6;
	localparam int CFG_MACRO_BIT = 7;
	localparam int CMD_DEST_LSB = 3;
	localparam int CMD_GIVEN_BIT = 5;
	localparam int ST_CHK_BIT = 1;
	localparam int ST_MACRO_BIT = 2;
	localparam int ST_LEN_BIT = 3;
	localparam logic [2:0] OP_CURVE_CMD = 3'h1;
	localparam logic [2:0] OP_CURVE_QRY = 3'h2;
	localparam logic [2:0] OP_WPRE_QRY = 3'h3;
	localparam logic [2:0] OP_COMBINED = 3'h4;
	localparam logic [2:0] OP_DISPLAY_PREAMBLE_QUERY_QRY = 3'h5;
	localparam logic [2:0] OP_COPY_QRY = 3'h6;
	localparam logic [9:0] PTS_FULL = 10'h3E8;
	localparam logic [9:0] PTS_HALF = 10'h1F4;
	localparam logic [9:0] OFF_FULL_FREQ = 10'h1F4;
	localparam logic [9:0] OFF_HALF_FREQ = 10'h0FA;
	localparam logic [9:0] OFF_TIME = 10'h000;
	localparam logic [6:0] XDIV_FULL = 7'h64;
	localparam logic [6:0] XDIV_HALF = 7'h32;
	localparam logic [7:0] Y_OFFSET_LOG = 8'hE1;
	localparam logic [7:0] Y_OFFSET_LIN = 8'h19;
	localparam logic [7:0] YSCALE_DIV = 8'h19;
	localparam logic [63:0] DISPLAY_PREAMBLE_QUERY_VEC = 64'h04_01_F7_08_08_01_00_0A;
	localparam logic [3:0] WPRE_LEN = 4'h9;
	localparam logic [3:0] DISPLAY_PREAMBLE_QUERY_LEN = 4'h8;
	localparam logic [7:0] ID_CODE = 8'h5A; // arbitrary value
	localparam logic [7:0] CH_PERCENT = 8'h25;
	localparam logic [7:0] CH_AT = 8'h40;
	localparam logic [7:0] CH_COMMA = 8'h2C;
	localparam logic [7:0] CH_ZERO = 8'h30;
	typedef enum logic [1:0] {SEL_A, SEL_B, SEL_FULL} trace_sel_t;
	typedef enum logic [1:0] {SEC_ID, SEC_WPRE, SEC_DISPLAY_PREAMBLE_QUERY, SEC_CURVE} sec_t;
	typedef enum logic [3:0] {R_IDLE, R_FIRST, R_CNT_HI, R_CNT_LO, R_BDATA,
		R_BSUM, R_END, R_ASCII, R_COMMIT} rx_st_t;
endpackage

/* File: waveform_transfer_framer.sv */
// Waveform transfer framer with APB register access
`timescale 1ns/1ns
`default_nettype none
module waveform_transfer_framer
(
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [framer_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          rx_valid,
	input  wire logic [7:0]                    rx_byte,
	input  wire logic                          rx_eoi,
	output logic                               tx_valid,
	output logic      [7:0]                    tx_byte,
	output logic                               tx_eoi,
	input  wire logic                          tx_ready,
	input  wire logic                          sweep_valid,
	input  wire logic [9:0]                    sweep_pos,
	input  wire logic [7:0]                    sweep_val
);
	import framer_pkg::*;

	function automatic logic [9:0] pos_of(trace_sel_t s, logic [9:0] p);
		unique case (s)
			SEL_A:   pos_of = {p[8:0], 1'b1};
			SEL_B:   pos_of = {p[8:0], 1'b0};
			default: pos_of = p;
		endcase
	endfunction

	// --------------------------------------------------
	// Configuration and APB decode
	// --------------------------------------------------
	trace_sel_t sel_q;
	trace_sel_t sel_d;
	trace_sel_t sel_req;
	logic       enc_q, mpc_q, mpc_d, hold_q, freq_q, log_q, macro_q;
	logic [3:0] pend_q;
	logic [2:0] err_q;
	logic       cq_seen_q;
	rx_st_t     rst_q;
	logic [7:0] trace_q [0:999];
	logic [7:0] xbuf_q [0:999];

	wire setup = psel && !penable;
	wire wr = psel && penable && pready && pwrite;
	wire a_cfg = paddr == ADDR_CONFIG;
	wire a_cmd = paddr == ADDR_COMMAND;
	wire a_st = paddr == ADDR_STATUS;
	wire a_pre = paddr == ADDR_PREAMBLE;
	wire a_scl = paddr == ADDR_SCALE;
	wire a_set = paddr == ADDR_SETTINGS;
	wire mapped = a_cfg || a_cmd || a_st || a_pre || a_scl || a_set;
	wire cfg_wr = wr && a_cfg;
	wire cmd_wr = wr && a_cmd;
	wire [2:0] op = pwdata[2:0];
	wire [1:0] dest = pwdata[CMD_DEST_LSB+1:CMD_DEST_LSB];
	wire curve_cmd = cmd_wr && op == OP_CURVE_CMD;
	wire curve_ok = curve_cmd && !macro_q && rst_q == R_IDLE;
	wire macro_rej = curve_cmd && macro_q;
	wire dest_wr = curve_ok && pwdata[CMD_GIVEN_BIT] && dest != 2'h3;
	wire cfg_legal = pwdata[1:0] != 2'h3;
	wire full = sel_q == SEL_FULL;
	wire [9:0] npts = full ? PTS_FULL : PTS_HALF;
	wire [9:0] poff = !freq_q ? OFF_TIME :
		(full ? OFF_FULL_FREQ : OFF_HALF_FREQ);
	wire [6:0] xdiv = full ? XDIV_FULL : XDIV_HALF;
	wire [7:0] y_offset = log_q ? Y_OFFSET_LOG : Y_OFFSET_LIN;
	wire [71:0] wpre_vec = {YSCALE_DIV, y_offset, 1'b0, xdiv, poff[7:0],
		6'h00, poff[9:8], npts[7:0], 6'h00, npts[9:8], 7'h00, enc_q,
		6'h00, sel_q};

	// Newest selection wins; coupling and half traces exclude each other
	assign sel_req = cfg_wr ? (cfg_legal ? trace_sel_t'(pwdata[1:0]) : sel_q)
		: (dest_wr ? trace_sel_t'(dest) : sel_q);
	assign sel_d = (cfg_wr && pwdata[CFG_MPC_BIT]) ? SEL_FULL : sel_req;
	assign mpc_d = cfg_wr ? pwdata[CFG_MPC_BIT] :
		((dest_wr && sel_req != SEL_FULL) ? 1'b0 : mpc_q);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sel_q <= SEL_FULL;
			enc_q <= 1'b0;
			mpc_q <= 1'b0;
			{hold_q, freq_q, log_q, macro_q} <= 4'h0;
		end
		else
		begin
			sel_q <= sel_d;
			mpc_q <= mpc_d;
			if (cfg_wr)
			begin
				enc_q <= pwdata[CFG_ENC_BIT];
				hold_q <= pwdata[CFG_HOLD_BIT];
				freq_q <= pwdata[CFG_FREQ_BIT];
				log_q <= pwdata[CFG_LOG_BIT];
				macro_q <= pwdata[CFG_MACRO_BIT];
			end
		end
	end

	// --------------------------------------------------
	// Register read path
	// --------------------------------------------------
	wire tx_busy = |pend_q || tx_valid;
	wire [31:0] cfg_rd = {24'h0, macro_q, log_q, freq_q, hold_q, mpc_q,
		enc_q, sel_q};
	wire [31:0] st_rd = {27'h0, rst_q != R_IDLE, err_q, tx_busy};
	wire [31:0] pre_rd = {5'h00, xdiv, poff, npts};
	wire [31:0] scl_rd = {16'h0000, YSCALE_DIV, y_offset};
	wire [31:0] set_rd = {29'h0, enc_q, sel_q};
	wire [31:0] rd_mux = a_cfg ? cfg_rd : a_st ? st_rd : a_pre ? pre_rd :
		a_scl ? scl_rd : a_set ? set_rd : 32'h0000_0000;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup && !mapped;
			prdata <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// --------------------------------------------------
	// Receive parser
	// --------------------------------------------------
	logic [15:0] rcnt_q;
	logic [9:0]  ridx_q, racc_q, cidx_q;
	logic [7:0]  rsum_q;
	wire take = rx_valid && rst_q != R_IDLE && rst_q != R_COMMIT;
	wire digit = rx_byte >= CH_ZERO && rx_byte <= 8'h39;
	wire [7:0] dval = rx_byte - CH_ZERO;
	wire [9:0] acc_n = 10'(racc_q * 10'd10 + {2'b00, dval});
	wire asc = rst_q == R_ASCII || rst_q == R_FIRST;
	wire asc_put = asc && (rx_byte == CH_COMMA || (rx_eoi && digit));
	wire xw_en = take && !(rst_q == R_FIRST && !digit) &&
		(rst_q == R_BDATA || rst_q == R_END || asc_put) && ridx_q < PTS_FULL;
	wire [7:0] xw_val = asc ? (digit ? acc_n[7:0] : racc_q[7:0]) : rx_byte;
	wire [7:0] sum_n = rsum_q + rx_byte;
	wire [9:0] fin_cnt = 10'(ridx_q + {9'h000, xw_en});
	wire eoi_end = take && rx_eoi && (rst_q == R_END || asc);
	wire len_ok = fin_cnt == npts;
	wire sum_bad = take && rst_q == R_BSUM && sum_n != 8'h00;
	wire early = take && rx_eoi && (rst_q == R_CNT_HI ||
		rst_q == R_CNT_LO || rst_q == R_BDATA);
	wire cnt_bad = take && rst_q == R_CNT_LO &&
		{rcnt_q[7:0], rx_byte} != 16'({6'h00, npts} + 16'h0001);
	wire good_end = (eoi_end && len_ok) ||
		(take && rst_q == R_BSUM && !sum_bad);
	wire len_bad = (eoi_end && !len_ok) || early || cnt_bad;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rst_q <= R_IDLE;
			rcnt_q <= 16'h0000;
			ridx_q <= 10'h000;
			racc_q <= 10'h000;
			rsum_q <= 8'h00;
			cidx_q <= 10'h000;
		end
		else if (rst_q == R_IDLE)
		begin
			ridx_q <= 10'h000;
			racc_q <= 10'h000;
			cidx_q <= 10'h000;
			if (curve_ok)
				rst_q <= R_FIRST;
		end
		else if (rst_q == R_COMMIT)
		begin
			cidx_q <= cidx_q + 10'h001;
			if (cidx_q == npts - 10'h001)
				rst_q <= R_IDLE;
		end
		else if (take)
		begin
			if (xw_en)
				ridx_q <= ridx_q + 10'h001;
			racc_q <= digit ? acc_n : 10'h000;
			unique case (rst_q)
				R_FIRST:
					rst_q <= rx_byte == CH_PERCENT ? R_CNT_HI :
						rx_byte == CH_AT ? R_END : R_ASCII;
				R_CNT_HI:
					rst_q <= R_CNT_LO;
				R_CNT_LO:
					rst_q <= R_BDATA;
				R_BDATA:
					if (ridx_q == npts - 10'h001)
						rst_q <= R_BSUM;
				default:
					rst_q <= rst_q;
			endcase
			if (rst_q == R_FIRST || rst_q == R_CNT_HI)
				rcnt_q <= {rcnt_q[7:0], rx_byte};
			rsum_q <= (rst_q == R_FIRST) ? 8'h00 : sum_n;
			if (len_bad || sum_bad)
				rst_q <= R_IDLE;
			else if (good_end)
				rst_q <= cq_seen_q ? R_IDLE : R_COMMIT;
		end
	end

	// Transfer buffer and trace storage
	always_ff @(posedge clk)
	begin
		if (xw_en)
			xbuf_q[ridx_q] <= xw_val;
	end

	always_ff @(posedge clk)
	begin
		if (rst_q == R_COMMIT)
			trace_q[pos_of(sel_q, cidx_q)] <= xbuf_q[cidx_q];
		else if (sweep_valid && (!sweep_pos[0] || !hold_q))
			trace_q[sweep_pos] <= sweep_val;
	end

	// Sticky errors; a new event outweighs a clear in the same cycle
	wire [2:0] err_set = {len_bad, macro_rej, sum_bad};
	wire [2:0] err_clr = (wr && a_st) ? pwdata[ST_LEN_BIT:ST_CHK_BIT] : 3'h0;
	wire q_ok = cmd_wr && !tx_busy;
	wire [3:0] pend_new = !q_ok ? 4'h0 :
		op == OP_CURVE_QRY ? 4'b1000 :
		op == OP_WPRE_QRY ? 4'b0010 :
		op == OP_COMBINED ? 4'b1010 :
		op == OP_DISPLAY_PREAMBLE_QUERY_QRY ? 4'b0100 :
		op == OP_COPY_QRY ? 4'b1111 : 4'h0;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			err_q <= 3'h0;
			cq_seen_q <= 1'b0;
		end
		else
		begin
			err_q <= (err_q & ~err_clr) | err_set;
			if (pend_new[3])
				cq_seen_q <= 1'b1;
			else if (rx_valid && rx_eoi)
				cq_seen_q <= 1'b0;
		end
	end

	// --------------------------------------------------
	// Transmit framer
	// --------------------------------------------------
	logic [10:0] tidx_q, nidx;
	logic [1:0]  dig_q, ndig, eff;
	logic [7:0]  tsum_q, cur_byte;
	logic        cur_last;
	sec_t        cur_sec;
	assign cur_sec = pend_q[0] ? SEC_ID : pend_q[1] ? SEC_WPRE :
		pend_q[2] ? SEC_DISPLAY_PREAMBLE_QUERY : SEC_CURVE;
	wire [3:0] cur_bit = 4'b0001 << cur_sec;
	wire [9:0] pt = enc_q ? 10'(tidx_q - 11'h003) : tidx_q[9:0];
	wire [7:0] rd_val = trace_q[pos_of(sel_q, pt)];
	wire [15:0] bcnt = 16'({6'h00, npts} + 16'h0001);
	wire tx_load = (!tx_valid || tx_ready) && |pend_q;
	wire last_pt = pt == npts - 10'h001;
	wire [1:0] start = rd_val >= 8'h64 ? 2'h0 : rd_val >= 8'h0A ? 2'h1 : 2'h2;

	always_comb
	begin
		cur_byte = ID_CODE;
		cur_last = 1'b1;
		nidx = tidx_q + 11'h001;
		ndig = 2'h0;
		eff = (dig_q == 2'h0) ? start : dig_q;
		unique case (cur_sec)
			SEC_ID:
				cur_last = 1'b1;
			SEC_WPRE:
			begin
				cur_byte = wpre_vec[{tidx_q[3:0], 3'b000} +: 8];
				cur_last = tidx_q[3:0] == WPRE_LEN - 4'h1;
			end
			SEC_DISPLAY_PREAMBLE_QUERY:
			begin
				cur_byte = DISPLAY_PREAMBLE_QUERY_VEC[{tidx_q[2:0], 3'b000} +: 8];
				cur_last = tidx_q[3:0] == DISPLAY_PREAMBLE_QUERY_LEN - 4'h1;
			end
			SEC_CURVE:
				if (enc_q)
				begin
					cur_last = tidx_q == 11'({1'b0, npts} + 11'h003);
					cur_byte = tidx_q == 11'h000 ? CH_PERCENT :
						tidx_q == 11'h001 ? bcnt[15:8] :
						tidx_q == 11'h002 ? bcnt[7:0] :
						cur_last ? 8'(-tsum_q) : rd_val;
				end
				else
				begin
					cur_byte = eff == 2'h3 ? CH_COMMA : eff == 2'h0 ?
						8'(CH_ZERO + rd_val / 8'h64) : eff == 2'h1 ?
						8'(CH_ZERO + (rd_val / 8'h0A) % 8'h0A) :
						8'(CH_ZERO + rd_val % 8'h0A);
					cur_last = eff == 2'h2 && last_pt;
					nidx = eff == 2'h3 ? tidx_q + 11'h001 : tidx_q;
					ndig = eff == 2'h3 ? 2'h0 : eff + 2'h1;
				end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tx_valid <= 1'b0;
			tx_byte <= 8'h00;
			tx_eoi <= 1'b0;
			pend_q <= 4'h0;
			tidx_q <= 11'h000;
			dig_q <= 2'h0;
			tsum_q <= 8'h00;
		end
		else
		begin
			if (tx_load)
			begin
				tx_valid <= 1'b1;
				tx_byte <= cur_byte;
				tx_eoi <= cur_last && (pend_q & ~cur_bit) == 4'h0;
				tidx_q <= cur_last ? 11'h000 : nidx;
				dig_q <= cur_last ? 2'h0 : ndig;
				tsum_q <= tidx_q == 11'h000 ? 8'h00 : tsum_q + cur_byte;
			end
			else if (tx_ready)
			begin
				tx_valid <= 1'b0;
				tx_eoi <= 1'b0;
			end
			pend_q <= (pend_q & ~((tx_load && cur_last) ? cur_bit : 4'h0))
				| pend_new;
		end
	end

	// --------------------------------------------------
	// Assertions
	// --------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence tx_done_s;
		tx_valid && tx_ready && tx_eoi;
	endsequence

	reset_default_a: assert property ($rose(rst_n) |-> sel_q == SEL_FULL
		&& !enc_q) else $error("bad reset format");
	coupling_full_a: assert property (mpc_q |-> sel_q == SEL_FULL)
		else $error("coupling without full");
	half_clears_a: assert property (dest_wr && dest != 2'h2 && !cfg_wr
		|=> !mpc_q && sel_q != SEL_FULL) else $error("half kept");
	count_match_a: assert property (pre_rd[9:0] == (sel_q == SEL_FULL ?
		10'h3E8 : 10'h1F4)) else $error("bad point count");
	offset_val_a: assert property (!freq_q |-> pre_rd[19:10] == 10'h000)
		else $error("bad time offset");
	checksum_zero_a: assert property (tx_load && cur_sec == SEC_CURVE && enc_q
		&& cur_last |-> 8'(tsum_q + cur_byte) == 8'h00)
		else $error("bad checksum");
	eoi_ends_a: assert property (tx_done_s ##1 1'b1 |-> !tx_valid)
		else $error("byte after end");
	macro_reject_a: assert property (macro_rej |=> err_q[1] &&
		$stable(rst_q)) else $error("macro curve taken");
	hold_keep_a: assert property (sweep_valid && sweep_pos[0] && hold_q
		&& rst_q != R_COMMIT |=> trace_q[$past(sweep_pos)] ==
		$past(trace_q[sweep_pos])) else $error("A overwritten");
	bad_sum_a: assert property (sum_bad |=> err_q[0] && rst_q == R_IDLE)
		else $error("bad sum kept");
endmodule
`default_nettype wire

/* File: ctrl_model.sv */
// Remote controller model: feeds received bytes, drains transmitted ones
`timescale 1ns/1ns
`default_nettype none
module ctrl_model
(
	input  wire logic       clk,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_byte,
	input  wire logic       tx_eoi,
	output logic            tx_ready,
	output logic            rx_valid,
	output logic [7:0]      rx_byte,
	output logic            rx_eoi
);
	logic [7:0] got[$];
	int         ends;
	int         eoi_at;
	logic       slow;
	logic [1:0] ph;
	initial
	begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_byte = 8'h00;
		rx_eoi = 1'b0;
		slow = 1'b0;
		ph = 2'h0;
		ends = 0;
		eoi_at = 0;
	end
	// -----------------------------------------------------------
	// Drain with optional stalls
	// -----------------------------------------------------------
	always @(posedge clk)
	begin
		if (tx_valid && tx_ready)
		begin
			got.push_back(tx_byte);
			if (tx_eoi)
			begin
				ends++;
				eoi_at = got.size();
			end
		end
		ph <= ph + 2'h1;
		tx_ready <= !slow || (ph == 2'h0);
	end
	// -----------------------------------------------------------
	// Byte sender; line shows the inverse once released
	// -----------------------------------------------------------
	task automatic put(input logic [7:0] b, input logic e);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_byte <= b;
		rx_eoi <= e;
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_byte <= ~b;
		rx_eoi <= 1'b0;
	endtask
	// Percent, count of data plus one, data, sum byte
	task automatic send_block(input logic [7:0] d[$], input logic bad);
		logic [15:0] c;
		logic [7:0]  s;
		c = 16'(d.size() + 1);
		s = c[15:8] + c[7:0];
		put(8'h25, 1'b0);
		put(c[15:8], 1'b0);
		put(c[7:0], 1'b0);
		foreach (d[i])
		begin
			put(d[i], 1'b0);
			s = s + d[i];
		end
		put((-s) ^ {7'h00, bad}, 1'b1);
	endtask
endmodule
`default_nettype wire

/* File: tb_waveform_transfer_framer.sv */
// Testbench for the waveform transfer framer
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) \
	begin \
		total_checks++; \
		if ((gt) !== (ex)) \
		begin \
			err_count++; \
			$display("FAIL %s exp %0h got %0h", nm, ex, gt); \
		end \
	end
module tb_waveform_transfer_framer;
	import framer_pkg::*;
	logic        clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rx_valid;
	logic [7:0]  rx_byte;
	logic        rx_eoi;
	logic        tx_valid;
	logic [7:0]  tx_byte;
	logic        tx_eoi;
	logic        tx_ready;
	logic        sweep_valid;
	logic [9:0]  sweep_pos;
	logic [7:0]  sweep_val;
	logic [31:0] rd;
	logic        rerr;
	logic [7:0]  ex[$];
	logic [7:0]  dp[8] = '{8'h0A, 8'h00, 8'h01, 8'h08, 8'h08, 8'hF7,
		8'h01, 8'h04};
	int          err_count;
	int          total_checks;
	always #4 clk = ~clk;
	waveform_transfer_framer waveform_transfer_framer_i (.clk(clk),
		.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_valid(rx_valid), .rx_byte(rx_byte),
		.rx_eoi(rx_eoi), .tx_valid(tx_valid), .tx_byte(tx_byte),
		.tx_eoi(tx_eoi), .tx_ready(tx_ready), .sweep_valid(sweep_valid),
		.sweep_pos(sweep_pos), .sweep_val(sweep_val));
	ctrl_model ctrl_model_i (.clk(clk), .tx_valid(tx_valid),
		.tx_byte(tx_byte), .tx_eoi(tx_eoi), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_byte(rx_byte), .rx_eoi(rx_eoi));
	// -----------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20)
		begin
			err_count++;
			tally_and_finish();
		end
	endtask
	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(nm, e, rd & m)
	endtask
	task automatic query(input logic [2:0] op);
		int n;
		ctrl_model_i.got.delete();
		ctrl_model_i.ends = 0;
		apb(1'b1, ADDR_COMMAND, {29'h0, op});
		n = 0;
		while (ctrl_model_i.ends == 0 && n < 20000)
		begin
			@(posedge clk);
			n++;
		end
		if (n == 20000)
		begin
			err_count++;
			tally_and_finish();
		end
	endtask
	task automatic curve_chk(input int n);
		logic [15:0] c;
		logic [7:0]  s;
		c = 16'(n + 1);
		s = c[15:8] + c[7:0];
		`CHK("size", n + 4, ctrl_model_i.got.size())
		`CHK("lead", 8'h25, ctrl_model_i.got[0])
		`CHK("count_hi", c[15:8], ctrl_model_i.got[1])
		`CHK("count_lo", c[7:0], ctrl_model_i.got[2])
		for (int i = 0; i < n; i++)
		begin
			`CHK("point", ex[i], ctrl_model_i.got[3 + i])
			s = s + ex[i];
		end
		`CHK("checksum", 8'(-s), ctrl_model_i.got[n + 3])
		`CHK("eoi_pos", n + 4, ctrl_model_i.eoi_at)
	endtask
	task automatic sweep(input logic [7:0] f);
		for (int p = 0; p < 1000; p++)
		begin
			@(posedge clk);
			sweep_valid <= 1'b1;
			sweep_pos <= 10'(p);
			sweep_val <= 8'(p) ^ f;
		end
		@(posedge clk);
		sweep_valid <= 1'b0;
	endtask
	// -----------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sweep_valid = 1'b0;
		sweep_pos = 10'h000;
		sweep_val = 8'h00;
		err_count = 0;
		total_checks = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rchk("config", ADDR_CONFIG, 32'hFF, 32'h02);
		rchk("settings", ADDR_SETTINGS, 32'hFFFFFFFF, 32'h2);
		rchk("preamble", ADDR_PREAMBLE, 32'h07FFFFFF, 32'h064003E8);
		rchk("scale", ADDR_SCALE, 32'hFFFF, 32'h1919);
		apb(1'b1, ADDR_CONFIG, 32'h60);
		rchk("preamble", ADDR_PREAMBLE, 32'h07FFFFFF, 32'h0323E9F4);
		rchk("scale", ADDR_SCALE, 32'hFFFF, 32'h19E1);
		apb(1'b0, 8'h20, 32'h0);
		`CHK("slverr", 1'b1, rerr)
		apb(1'b1, ADDR_CONFIG, 32'h06);
		sweep(8'h3C);
		apb(1'b1, ADDR_CONFIG, 32'h16);
		sweep(8'hC3);
		for (int i = 0; i < 1000; i++)
			ex.push_back(8'(i) ^ (i[0] ? 8'h3C : 8'hC3));
		ctrl_model_i.slow = 1'b1;
		query(OP_CURVE_QRY);
		curve_chk(1000);
		ctrl_model_i.slow = 1'b0;
		ctrl_model_i.put(8'h0A, 1'b1);
		apb(1'b1, ADDR_COMMAND, 32'h29);
		ex.delete();
		for (int k = 0; k < 500; k++)
			ex.push_back(8'(k) ^ 8'hA5);
		ctrl_model_i.send_block(ex, 1'b0);
		repeat (520) @(posedge clk);
		rchk("settings", ADDR_SETTINGS, 32'hFFFFFFFF, 32'h5);
		query(OP_CURVE_QRY);
		curve_chk(500);
		apb(1'b1, ADDR_COMMAND, 32'h01);
		ctrl_model_i.send_block(ex, 1'b1);
		repeat (20) @(posedge clk);
		rchk("status", ADDR_STATUS, 32'hA, 32'h2);
		query(OP_DISPLAY_PREAMBLE_QUERY_QRY);
		for (int i = 0; i < 8; i++)
			`CHK("display_preamble_query", dp[i], ctrl_model_i.got[i])
		`CHK("display_preamble_query_eoi", 8, ctrl_model_i.eoi_at)
		query(OP_COMBINED);
		`CHK("comb_trace", 8'h01, ctrl_model_i.got[0])
		`CHK("comb_pts", 8'hF4, ctrl_model_i.got[3])
		`CHK("comb_curve", 8'h25, ctrl_model_i.got[9])
		query(OP_COPY_QRY);
		`CHK("copy_id", ID_CODE, ctrl_model_i.got[0])
		`CHK("copy_display_preamble_query", 8'h0A, ctrl_model_i.got[10])
		`CHK("copy_curve", 8'h25, ctrl_model_i.got[18])
		apb(1'b1, ADDR_CONFIG, 32'h08);
		rchk("coupled", ADDR_SETTINGS, 32'hFFFFFFFF, 32'h2);
		query(OP_CURVE_QRY);
		`CHK("asc_d0", 8'h31, ctrl_model_i.got[0])
		`CHK("asc_d1", 8'h36, ctrl_model_i.got[1])
		`CHK("asc_d2", 8'h35, ctrl_model_i.got[2])
		`CHK("asc_sep", 8'h2C, ctrl_model_i.got[3])
		`CHK("asc_d3", 8'h36, ctrl_model_i.got[4])
		`CHK("asc_last", 8'h39, ctrl_model_i.got[ctrl_model_i.got.size() - 1])
		`CHK("asc_eoi", ctrl_model_i.got.size(), ctrl_model_i.eoi_at)
		apb(1'b1, ADDR_CONFIG, 32'h85);
		apb(1'b1, ADDR_COMMAND, 32'h01);
		rchk("macro", ADDR_STATUS, 32'h4, 32'h4);
		tally_and_finish();
	end
endmodule
`default_nettype wire
